// [logic/clock_buffer_defines.svh]
`ifndef CLOCK_BUFFER_DEFINES_SVH
`define CLOCK_BUFFER_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define REG_COUNT 5
`define IDX_OUTPUT_ENABLE_CTL 8'h00
`define IDX_PLL_MODE_AMPLITUDE_CTL 8'h01
`define IDX_OUTPUT_SLEW_CTL 8'h02
`define IDX_FREQUENCY_FEEDBACK_SLEW_CTL 8'h03
`define IDX_RESERVED_FOUR 8'h04

// ****************************************
// field positions
// ****************************************
`define OUT1_ENABLE_BIT 4
`define OUT0_ENABLE_BIT 3
`define PLL_LATCHED_HI 7
`define PLL_LATCHED_LO 6
`define PLL_SOURCE_BIT 5
`define PLL_SOFT_HI 4
`define PLL_SOFT_LO 3
`define AMPLITUDE_HI 1
`define AMPLITUDE_LO 0
`define OUT1_EDGE_BIT 4
`define OUT0_EDGE_BIT 3
`define FREQ_ENABLE_BIT 5
`define FREQ_CODE_HI 4
`define FREQ_CODE_LO 3
`define FEEDBACK_EDGE_BIT 0

// ****************************************
// reset values and writable masks
// ****************************************
`define RESET_B0 8'h18
`define RESET_B1 8'h06
`define RESET_B2 8'hdd
`define RESET_B3 8'hc5
`define RESET_B4 8'h00
`define MASK_B0 8'h18
`define MASK_B1 8'h3b
`define MASK_B2 8'h18
`define MASK_B3 8'h39
`define MASK_B4 8'h00

// ****************************************
// encodings and counts
// ****************************************
`define FREQ_100M 2'h0
`define FREQ_50M 2'h1
`define FREQ_125M 2'h2
`define FREQ_RESERVED 2'h3
`define READ_COUNT_DFLT 8'h08
`define ADDR_SEL_LOW 2'h0
`define ADDR_SEL_MID 2'h1
`define TARGET_ADDR_LOW_DFLT 7'h10
`define TARGET_ADDR_MID_DFLT 7'h11
`define TARGET_ADDR_HIGH_DFLT 7'h12

`endif

// [logic/clock_buffer_pkg.sv]
`include "clock_buffer_defines.svh"

package clock_buffer_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INDEX,
    ST_COUNT,
    ST_WDATA,
    ST_TX,
    ST_IGNORE
  } link_state_t;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
  } wr_req_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [`REG_COUNT-1:0][7:0] image;
  } link_view_t;

  typedef struct packed {
    logic out0En;
    logic out1En;
    logic out0Edge;
    logic out1Edge;
    logic feedbackEdge;
    logic [1:0] amplitude;
    logic [1:0] pllMode;
    logic [1:0] freqCode;
    logic freqSelEnable;
  } clock_ctl_t;

endpackage : clock_buffer_pkg

// [logic/sync_two_flop.sv]
`timescale 1ns/1ps

module sync_two_flop #(
  parameter int WIDTH = 1
) (
  // clocking
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_r <= '0;
      q_r <= '0;
    end else if (clockEnable) begin
      stage_r <= d;
      q_r <= stage_r;
    end
  end

  assign q = q_r;

endmodule : sync_two_flop

// [logic/toggle_pulse.sv]
`timescale 1ns/1ps

module toggle_pulse (
  // clocking
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  // event
  input wire logic toggleIn,
  output logic pulse
);

  logic stage_r;
  logic level_r;
  logic prev_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_r <= 1'b0;
      level_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (clockEnable) begin
      stage_r <= toggleIn;
      level_r <= stage_r;
      prev_r <= level_r;
    end
  end

  // one pulse per toggle, only while enabled
  assign pulse = clockEnable & (level_r ^ prev_r);

endmodule : toggle_pulse

// [logic/clock_buffer_smbus_config.sv]
`timescale 1ns/1ps
`include "clock_buffer_defines.svh"

module clock_buffer_smbus_config #(
  parameter logic [7:0] READ_COUNT = `READ_COUNT_DFLT,
  parameter logic [6:0] TARGET_ADDR_LOW = `TARGET_ADDR_LOW_DFLT,
  parameter logic [6:0] TARGET_ADDR_MID = `TARGET_ADDR_MID_DFLT,
  parameter logic [6:0] TARGET_ADDR_HIGH = `TARGET_ADDR_HIGH_DFLT
) (
  // system
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  // power-up straps
  input wire logic powerGood,
  input wire logic [1:0] targetAddrSelectPin,
  input wire logic [1:0] pllModeSelectPin,
  // output enable pins
  input wire logic out0EnablePinN,
  input wire logic out1EnablePinN,
  // smbus link
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // clock control
  output clock_buffer_pkg::clock_ctl_t clockCtl
);

  import clock_buffer_pkg::*;

  // ****************************************
  // link domain: start detection
  // ****************************************
  // scl and sda are timed against each other by the bus, so the detector
  // runs on the sda falling edge and is read at the next scl falling edge
  logic startTgl_r;
  logic startAck_r;
  logic sdaSample_r;

  always_ff @(negedge sdaIn or posedge rst) begin
    if (rst) begin
      startTgl_r <= 1'b0;
    end else if (scl) begin
      startTgl_r <= ~startTgl_r;
    end
  end

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      sdaSample_r <= 1'b1;
    end else begin
      sdaSample_r <= sdaIn;
    end
  end

  // ****************************************
  // link domain: view of registers
  // ****************************************
  link_view_t viewSrc;
  link_view_t view;

  sync_two_flop #(
    .WIDTH($bits(link_view_t))
  ) u_view_sync (
    .clock(scl),
    .rst(rst),
    .clockEnable(1'b1),
    .d(viewSrc),
    .q(view)
  );

  // ****************************************
  // link domain: byte engine
  // ****************************************
  link_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] txShift_r, txShift_nxt;
  logic [7:0] index_r, index_nxt;
  logic [7:0] remain_r, remain_nxt;
  logic rw_r, rw_nxt;
  logic acked_r, acked_nxt;
  logic sdaOeN_r, sdaOeN_nxt;
  logic wrTgl_r, wrTgl_nxt;
  wr_req_t wrReq_r, wrReq_nxt;
  logic sdaOut_r;

  wire startHit = startTgl_r ^ startAck_r;
  wire [7:0] rxByte = {shift_r[6:0], sdaSample_r};
  wire addrHit = view.valid && (rxByte[7:1] == view.addr);
  wire rxAck = (state_r == ST_ADDR) ? addrHit : 1'b1;
  wire inMap = (index_r < 8'(`REG_COUNT));
  wire [7:0] readByte = inMap ? view.image[index_r[2:0]] : 8'h00;
  wire hostAck = ~sdaSample_r;
  wire storeByte = (remain_r != 8'h00);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    txShift_nxt = txShift_r;
    index_nxt = index_r;
    remain_nxt = remain_r;
    rw_nxt = rw_r;
    acked_nxt = acked_r;
    sdaOeN_nxt = sdaOeN_r;
    wrTgl_nxt = wrTgl_r;
    wrReq_nxt = wrReq_r;
    if (startHit) begin
      // a repeated start keeps the index from the write phase
      state_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      sdaOeN_nxt = 1'b1;
    end else begin
      case (state_r)
        ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA: begin
          if (cnt_r != 4'h8) begin
            shift_nxt = rxByte;
            cnt_nxt = 4'(cnt_r + 4'h1);
            if (cnt_r == 4'h7) begin
              sdaOeN_nxt = ~rxAck;
              if (state_r == ST_ADDR) begin
                rw_nxt = rxByte[0];
                acked_nxt = rxAck;
              end
              if (state_r == ST_WDATA && storeByte) begin
                wrTgl_nxt = ~wrTgl_r;
                wrReq_nxt = '{idx: index_r, data: rxByte};
              end
            end
          end else begin
            cnt_nxt = 4'h0;
            sdaOeN_nxt = 1'b1;
            case (state_r)
              ST_ADDR: begin
                if (!acked_r) begin
                  state_nxt = ST_IGNORE;
                end else if (rw_r) begin
                  state_nxt = ST_TX;
                  txShift_nxt = READ_COUNT;
                  remain_nxt = READ_COUNT;
                  sdaOeN_nxt = READ_COUNT[7];
                end else begin
                  state_nxt = ST_INDEX;
                end
              end
              ST_INDEX: begin
                index_nxt = shift_r;
                state_nxt = ST_COUNT;
              end
              ST_COUNT: begin
                remain_nxt = shift_r;
                state_nxt = ST_WDATA;
              end
              default: begin
                if (storeByte) begin
                  index_nxt = 8'(index_r + 8'h01);
                  remain_nxt = 8'(remain_r - 8'h01);
                end
              end
            endcase
          end
        end
        ST_TX: begin
          if (cnt_r < 4'h7) begin
            txShift_nxt = {txShift_r[6:0], 1'b1};
            sdaOeN_nxt = txShift_r[6];
            cnt_nxt = 4'(cnt_r + 4'h1);
          end else if (cnt_r == 4'h7) begin
            sdaOeN_nxt = 1'b1;
            cnt_nxt = 4'h8;
          end else if (hostAck && storeByte) begin
            // host acked, next byte from index
            txShift_nxt = readByte;
            sdaOeN_nxt = readByte[7];
            index_nxt = 8'(index_r + 8'h01);
            remain_nxt = 8'(remain_r - 8'h01);
            cnt_nxt = 4'h0;
          end else begin
            // not-ack or count used up: let go of the bus
            state_nxt = ST_IGNORE;
            sdaOeN_nxt = 1'b1;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sdaOeN_nxt = 1'b1;
        end
        default: begin
          state_nxt = ST_IDLE;
          sdaOeN_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      txShift_r <= 8'hff;
      index_r <= 8'h00;
      remain_r <= 8'h00;
      rw_r <= 1'b0;
      acked_r <= 1'b0;
      sdaOeN_r <= 1'b1;
      wrTgl_r <= 1'b0;
      wrReq_r <= '0;
      startAck_r <= 1'b0;
      sdaOut_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      txShift_r <= txShift_nxt;
      index_r <= index_nxt;
      remain_r <= remain_nxt;
      rw_r <= rw_nxt;
      acked_r <= acked_nxt;
      sdaOeN_r <= sdaOeN_nxt;
      wrTgl_r <= wrTgl_nxt;
      wrReq_r <= wrReq_nxt;
      startAck_r <= startTgl_r;
      sdaOut_r <= 1'b0;
    end
  end

  assign sdaOut = sdaOut_r;
  assign sdaOeN = sdaOeN_r;

  // ****************************************
  // system domain: pins and straps
  // ****************************************
  logic [6:0] pinsSync;
  logic strapDone_r;
  logic [6:0] targetAddr_r;
  logic [1:0] pllLatched_r;
  logic wrPulse;

  sync_two_flop #(
    .WIDTH(7)
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .d({powerGood, targetAddrSelectPin, pllModeSelectPin, out1EnablePinN, out0EnablePinN}),
    .q(pinsSync)
  );

  wire pgSync = pinsSync[6];
  wire [1:0] addrSelSync = pinsSync[5:4];
  wire [1:0] modeSelSync = pinsSync[3:2];
  wire [1:0] oePinNSync = pinsSync[1:0];
  wire strapTake = clockEnable && pgSync && !strapDone_r;
  wire [6:0] addrPick = (addrSelSync == `ADDR_SEL_LOW) ? TARGET_ADDR_LOW :
                        (addrSelSync == `ADDR_SEL_MID) ? TARGET_ADDR_MID : TARGET_ADDR_HIGH;

  // straps are taken once, after power good, never again until reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strapDone_r <= 1'b0;
      targetAddr_r <= 7'h00;
      pllLatched_r <= 2'h0;
    end else if (strapTake) begin
      strapDone_r <= 1'b1;
      targetAddr_r <= addrPick;
      pllLatched_r <= modeSelSync;
    end
  end

  toggle_pulse u_wr_event (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .toggleIn(wrTgl_r),
    .pulse(wrPulse)
  );

  // ****************************************
  // system domain: configuration bytes
  // ****************************************
  localparam logic [`REG_COUNT-1:0][7:0] WR_MASK =
    {`MASK_B4, `MASK_B3, `MASK_B2, `MASK_B1, `MASK_B0};
  localparam logic [`REG_COUNT-1:0][7:0] RST_VAL =
    {`RESET_B4, `RESET_B3, `RESET_B2, `RESET_B1, `RESET_B0};

  logic [`REG_COUNT-1:0][7:0] regByte_r;
  logic [`REG_COUNT-1:0][7:0] readImage;

  // wrReq_r is stable for a whole byte time once its toggle has arrived
  for (genvar i = 0; i < `REG_COUNT; i++) begin : g_reg
    wire hit = wrPulse && (wrReq_r.idx == 8'(i));
    wire [7:0] merged = (regByte_r[i] & ~WR_MASK[i]) | (wrReq_r.data & WR_MASK[i]);
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        regByte_r[i] <= RST_VAL[i];
      end else if (hit) begin
        regByte_r[i] <= merged;
      end
    end
    if (i == 1) begin : g_mode
      assign readImage[i] = {pllLatched_r, regByte_r[i][5:0]};
    end else begin : g_plain
      assign readImage[i] = regByte_r[i];
    end
  end

  assign viewSrc = '{valid: strapDone_r, addr: targetAddr_r, image: readImage};

  // ****************************************
  // system domain: control outputs
  // ****************************************
  wire [7:0] b0 = regByte_r[0];
  wire [7:0] b1 = regByte_r[1];
  wire [7:0] b2 = regByte_r[2];
  wire [7:0] b3 = regByte_r[3];
  wire [1:0] softMode = b1[`PLL_SOFT_HI:`PLL_SOFT_LO];
  wire [1:0] freqField = b3[`FREQ_CODE_HI:`FREQ_CODE_LO];
  wire freqEn = b3[`FREQ_ENABLE_BIT];
  clock_ctl_t ctl_r, ctl_nxt;

  always_comb begin
    ctl_nxt = ctl_r;
    ctl_nxt.out0En = b0[`OUT0_ENABLE_BIT] & ~oePinNSync[0];
    ctl_nxt.out1En = b0[`OUT1_ENABLE_BIT] & ~oePinNSync[1];
    ctl_nxt.pllMode = b1[`PLL_SOURCE_BIT] ? softMode : pllLatched_r;
    ctl_nxt.amplitude = b1[`AMPLITUDE_HI:`AMPLITUDE_LO];
    ctl_nxt.out0Edge = b2[`OUT0_EDGE_BIT];
    ctl_nxt.out1Edge = b2[`OUT1_EDGE_BIT];
    ctl_nxt.feedbackEdge = b3[`FEEDBACK_EDGE_BIT];
    ctl_nxt.freqSelEnable = freqEn;
    // reserved code leaves the running frequency alone
    if (!freqEn) begin
      ctl_nxt.freqCode = `FREQ_100M;
    end else if (freqField != `FREQ_RESERVED) begin
      ctl_nxt.freqCode = freqField;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_r <= '{out0En: 1'b0, out1En: 1'b0, out0Edge: 1'b1, out1Edge: 1'b1,
                 feedbackEdge: 1'b1, amplitude: 2'h2, pllMode: 2'h0,
                 freqCode: `FREQ_100M, freqSelEnable: 1'b0};
    end else if (clockEnable) begin
      ctl_r <= ctl_nxt;
    end
  end

  assign clockCtl = ctl_r;

  // ****************************************
  // assertions
  // ****************************************
  read_only_mode_a: assert property (@(posedge clock) disable iff (rst)
    wrPulse && wrReq_r.idx == `IDX_PLL_MODE_AMPLITUDE_CTL |=> readImage[1][7:6] == $past(pllLatched_r))
    else $error("pll mode readback changed by a write");
  soft_mode_store_a: assert property (@(posedge clock) disable iff (rst)
    wrPulse && wrReq_r.idx == `IDX_PLL_MODE_AMPLITUDE_CTL |=> softMode == $past(wrReq_r.data[4:3]))
    else $error("software pll mode not stored");
  out_enable_a: assert property (@(posedge clock) disable iff (rst)
    clockEnable && !b0[`OUT0_ENABLE_BIT] |=> !clockCtl.out0En)
    else $error("output 0 not forced off");
  mode_source_a: assert property (@(posedge clock) disable iff (rst)
    clockEnable && !b1[`PLL_SOURCE_BIT] |=> clockCtl.pllMode == $past(pllLatched_r))
    else $error("pll mode not from latched value");
  freq_gate_a: assert property (@(posedge clock) disable iff (rst)
    clockEnable && !freqEn |=> clockCtl.freqCode == `FREQ_100M)
    else $error("frequency changed while disabled");
  freq_apply_a: assert property (@(posedge clock) disable iff (rst)
    clockEnable && freqEn && freqField != `FREQ_RESERVED |=> clockCtl.freqCode == $past(freqField))
    else $error("frequency code not applied");
  edge_amp_a: assert property (@(posedge clock) disable iff (rst)
    clockEnable |=> clockCtl.amplitude == $past(b1[1:0]) && clockCtl.feedbackEdge == $past(b3[0]))
    else $error("amplitude or feedback edge wrong");
  reserved_bits_a: assert property (@(posedge clock) disable iff (rst)
    readImage[4] == `RESET_B4 && (b2 & ~`MASK_B2) == (`RESET_B2 & ~`MASK_B2))
    else $error("reserved bits disturbed");
  addr_hold_a: assert property (@(posedge clock) disable iff (rst)
    strapDone_r |=> strapDone_r && $stable(targetAddr_r))
    else $error("target address changed after latch");
  addr_ack_a: assert property (@(negedge scl) disable iff (rst)
    !startHit && state_r == ST_ADDR && cnt_r == 4'h7 |=> sdaOeN_r == !$past(addrHit))
    else $error("address acknowledge wrong");
  data_ack_a: assert property (@(negedge scl) disable iff (rst)
    !startHit && state_r == ST_WDATA && cnt_r == 4'h7 |=> !sdaOeN_r ##1 sdaOeN_r || startHit)
    else $error("data byte not acknowledged");
  count_first_a: assert property (@(negedge scl) disable iff (rst)
    !startHit && state_r == ST_ADDR && cnt_r == 4'h8 && acked_r && rw_r
    |=> state_r == ST_TX && txShift_r == READ_COUNT)
    else $error("count byte not sent first");

  write_seen_c: cover property (@(posedge clock) disable iff (rst)
    wrPulse && wrReq_r.idx == `IDX_FREQUENCY_FEEDBACK_SLEW_CTL);
  read_seen_c: cover property (@(negedge scl) disable iff (rst)
    state_r == ST_TX && cnt_r == 4'h8 && hostAck);
  restart_c: cover property (@(negedge scl) disable iff (rst)
    startHit && state_r == ST_COUNT);

endmodule : clock_buffer_smbus_config

// [testbench/smbus_host_model.sv]
`timescale 1ns/1ps

module smbus_host_model (
  // link wires
  output logic scl,
  output logic sdaPullLow,
  input wire logic sda,
  // observed results
  output logic resStrobe,
  output logic [7:0] resData
);
  // extra low time per bit, lets the bench play a slow host
  int lowExtra;

  initial begin
    scl = 1'b1;
    sdaPullLow = 1'b0;
    resStrobe = 1'b0;
    resData = 8'h00;
    lowExtra = 0;
  end

  task automatic report(input logic [7:0] v);
    resData = v;
    resStrobe = 1'b1;
    resStrobe <= #1 1'b0;
  endtask : report

  // ********
  // bit level
  // ********
  task automatic bitOut(input logic b);
    sdaPullLow = ~b;
    #7 scl = 1'b1;
    #15 scl = 1'b0;
    #(8 + lowExtra);
  endtask : bitOut

  task automatic bitIn(output logic b);
    sdaPullLow = 1'b0;
    #7 scl = 1'b1;
    #7 b = sda;
    #8 scl = 1'b0;
    #(8 + lowExtra);
  endtask : bitIn

  // also a repeated start, sda released before scl rises
  task automatic start();
    sdaPullLow = 1'b0;
    #7 scl = 1'b1;
    #8 sdaPullLow = 1'b1;
    #7 scl = 1'b0;
    #8;
  endtask : start

  task automatic stop();
    sdaPullLow = 1'b1;
    #7 scl = 1'b1;
    #8 sdaPullLow = 1'b0;
    #15;
  endtask : stop

  // ********
  // byte level
  // ********
  task automatic sendByte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(a);
    report({7'h00, ~a});
  endtask : sendByte

  task automatic recvByte(input logic last);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    report(d);
    bitOut(last);
  endtask : recvByte
endmodule : smbus_host_model

// [testbench/clock_buffer_smbus_config_test.sv]
`timescale 1ns/1ps
`include "clock_buffer_defines.svh"

module clock_buffer_smbus_config_test;
  import clock_buffer_pkg::*;

  logic clock;
  logic rst;
  logic clockEnable;
  logic powerGood;
  logic [1:0] targetAddrSelectPin;
  logic [1:0] pllModeSelectPin;
  logic out0EnablePinN;
  logic out1EnablePinN;
  logic scl;
  logic sdaPullLow;
  logic sdaOut;
  logic sdaOeN;
  logic resStrobe;
  logic [7:0] resData;
  wire logic sdaWire;
  clock_ctl_t clockCtl;
  logic [7:0] expQ[$];
  logic [7:0] regExp[5];
  logic [7:0] maskTab[5] = '{`MASK_B0, `MASK_B1, `MASK_B2, `MASK_B3, `MASK_B4};
  logic [6:0] devAddr;
  logic [15:0] noteNow;
  int errTotal;
  int nTests;
  logic [1:0] freqPrev;
  clock_ctl_t ctlNow;

  // open drain with pull-up: released reads high
  assign sdaWire = (sdaOeN ? 1'b1 : sdaOut) & ~sdaPullLow;

  clock_buffer_smbus_config i_clock_buffer_smbus_config (
    .clock(clock), .rst(rst), .clockEnable(clockEnable), .powerGood(powerGood),
    .targetAddrSelectPin(targetAddrSelectPin), .pllModeSelectPin(pllModeSelectPin),
    .out0EnablePinN(out0EnablePinN), .out1EnablePinN(out1EnablePinN),
    .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .clockCtl(clockCtl)
  );

  smbus_host_model i_smbus_host_model (
    .scl(scl), .sdaPullLow(sdaPullLow), .sda(sdaWire),
    .resStrobe(resStrobe), .resData(resData)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ********
  // checking
  // ********
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge resStrobe) begin
    noteNow = (expQ.size() != 0) ? {8'h00, expQ.pop_front()} : 16'hffff;
    check({8'h00, resData}, noteNow);
  end

  task automatic finishTest();
    if (errTotal == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finishTest

  function automatic clock_ctl_t ctlExp();
    clock_ctl_t c;
    c.out0En = regExp[0][3] & ~out0EnablePinN;
    c.out1En = regExp[0][4] & ~out1EnablePinN;
    c.out0Edge = regExp[2][3];
    c.out1Edge = regExp[2][4];
    c.feedbackEdge = regExp[3][0];
    c.amplitude = regExp[1][1:0];
    c.pllMode = regExp[1][5] ? regExp[1][4:3] : regExp[1][7:6];
    // reserved code keeps whatever frequency was running
    c.freqCode = !regExp[3][5] ? 2'h0 : (regExp[3][4:3] == 2'h3) ? freqPrev : regExp[3][4:3];
    c.freqSelEnable = regExp[3][5];
    return c;
  endfunction : ctlExp

  // ********
  // host transfers
  // ********
  task automatic putByte(input logic [7:0] d, input logic ack);
    expQ.push_back({7'h00, ack});
    i_smbus_host_model.sendByte(d);
  endtask : putByte

  task automatic blockWrite(input logic [7:0] n, input logic [7:0] d[$], input logic [7:0] cnt);
    i_smbus_host_model.start();
    putByte({devAddr, 1'b0}, 1'b1);
    putByte(n, 1'b1);
    putByte(cnt, 1'b1);
    foreach (d[k]) begin
      putByte(d[k], 1'b1);
      if (n + k < 5 && k < cnt) begin
        regExp[n + k] = (regExp[n + k] & ~maskTab[n + k]) | (d[k] & maskTab[n + k]);
      end
    end
    i_smbus_host_model.stop();
  endtask : blockWrite

  task automatic blockRead(input logic [7:0] n);
    i_smbus_host_model.start();
    putByte({devAddr, 1'b0}, 1'b1);
    putByte(n, 1'b1);
    i_smbus_host_model.start();
    putByte({devAddr, 1'b1}, 1'b1);
    expQ.push_back(`READ_COUNT_DFLT);
    i_smbus_host_model.recvByte(1'b0);
    for (int k = 0; k < 8; k++) begin
      expQ.push_back((n + k < 5) ? regExp[n + k] : 8'h00);
      i_smbus_host_model.recvByte(k == 7);
    end
    i_smbus_host_model.stop();
  endtask : blockRead

  // ********
  // main sequence
  // ********
  initial begin
    logic [7:0] d[$];
    logic [1:0] sel;
    logic [1:0] pllStrap;
    rst = 1'b1;
    clockEnable = 1'b1;
    powerGood = 1'b0;
    targetAddrSelectPin = 2'h0;
    pllModeSelectPin = 2'h0;
    out0EnablePinN = 1'b0;
    out1EnablePinN = 1'b0;
    errTotal = 0;
    nTests = 0;
    freqPrev = 2'h0;
    void'($urandom(32'h3a50));
    sel = 2'($urandom_range(2, 0));
    pllStrap = 2'($urandom);
    devAddr = (sel == 2'h0) ? `TARGET_ADDR_LOW_DFLT :
              (sel == 2'h1) ? `TARGET_ADDR_MID_DFLT : `TARGET_ADDR_HIGH_DFLT;
    regExp = '{`RESET_B0, `RESET_B1 | {pllStrap, 6'h00}, `RESET_B2, `RESET_B3, `RESET_B4};
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    targetAddrSelectPin <= sel;
    pllModeSelectPin <= pllStrap;
    @(posedge clock);
    powerGood <= 1'b1;
    repeat (10) @(posedge clock);
    // straps must stay latched after the pins move
    targetAddrSelectPin <= sel + 2'h1;
    pllModeSelectPin <= ~pllStrap;
    repeat (10) @(posedge clock);
    check(16'(clockCtl), 16'(ctlExp()));
    blockRead(8'h00);
    for (int i = 0; i < 6; i++) begin
      d = {};
      repeat (5) d.push_back(8'($urandom));
      d[1][1:0] = i[1:0];
      d[3][4:3] = (i == 2) ? 2'h3 : 2'(i % 3);
      d[3][5] = (i < 3);
      @(posedge clock);
      out0EnablePinN <= 1'($urandom);
      out1EnablePinN <= 1'($urandom);
      i_smbus_host_model.lowExtra = (i == 5) ? 200 : 0;
      blockWrite(8'h00, d, 8'h05);
      repeat (10) @(posedge clock);
      ctlNow = ctlExp();
      check(16'(clockCtl), 16'(ctlNow));
      freqPrev = ctlNow.freqCode;
      blockRead(8'(i % 2));
    end
    // enable low freezes the outputs, pins catch up once it returns
    @(posedge clock);
    ctlNow = ctlExp();
    clockEnable <= 1'b0;
    out0EnablePinN <= ~out0EnablePinN;
    out1EnablePinN <= ~out1EnablePinN;
    repeat (10) @(posedge clock);
    check(16'(clockCtl), 16'(ctlNow));
    clockEnable <= 1'b1;
    repeat (10) @(posedge clock);
    check(16'(clockCtl), 16'(ctlExp()));
    // count of one: the extra byte is acked but dropped
    d = '{8'($urandom), 8'($urandom)};
    blockWrite(8'h02, d, 8'h01);
    // foreign address: nothing acked, nothing stored
    i_smbus_host_model.start();
    putByte({devAddr ^ 7'h04, 1'b0}, 1'b0);
    putByte(8'h00, 1'b0);
    putByte(8'h01, 1'b0);
    putByte(8'h00, 1'b0);
    i_smbus_host_model.stop();
    blockRead(8'h00);
    repeat (20) @(posedge clock);
    if (expQ.size() != 0) check(16'(expQ.size()), 16'h0000);
    finishTest();
  end

  initial begin
    #400000;
    errTotal++;
    finishTest();
  end
endmodule : clock_buffer_smbus_config_test
